// *** shared/dpf_pkg.sv ***
package dpf_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_KEY = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  localparam logic [7:0] OFS_SWAP = 8'h10;
  localparam logic [7:0] OFS_BOOT = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
  localparam logic [7:0] OFS_RDDATA = 8'h20;
  // control register fields
  localparam int CTL_START_BIT = 15;
  localparam int CTL_BUSY_BIT = 14;
  localparam int CTL_ERR_BIT = 13;
  localparam int CTL_SWAP_DONE_BIT = 11;
  localparam int CTL_P2_ACTIVE_BIT = 10;
  localparam int CTL_PROTECT_BIT = 9;
  localparam int CTL_DUAL_BIT = 8;
  localparam int CTL_OP_LSB = 0;
  localparam int CTL_OP_W = 4;
  localparam logic [3:0] OP_WORD_PROG = 4'h1;
  localparam logic [3:0] OP_PAGE_ERASE = 4'h3;
  localparam logic [3:0] OP_PART_ERASE = 4'h4;
  localparam logic [3:0] OP_READ = 4'h5;
  // unlock key sequence
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // boot sequence word layout
  localparam int BOOT_SEQUENCE_NUMBER_W = 12;
  localparam int BOOT_SEQUENCE_NUMBER_WORD_W = 24;
  localparam logic [23:0] BOOT_SEQUENCE_NUMBER_WORD_RST = 24'hfff000;
  // inactive partition window offset used by bootloaders
  localparam logic [23:0] INACTIVE_OFFSET = 24'h400000;
  // flash geometry: 2 partitions x 8 pages x 16 words
  localparam int FA_W = 8;
  localparam int PAGE_LSB = 4;
  localparam int WORDS = 256;
  localparam int PART_BIT = 7;
  localparam logic [31:0] ERASED = 32'hffffffff;
  // interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_OP_DONE = 0;
  localparam int IRQ_SWAP = 1;
  localparam int IRQ_ERR = 2;
  // timing: a program step takes 1 us
  localparam int CLK_HZ = 10_000_000;
  localparam int PROG_TIME_NS = 1000;
  localparam int PROG_CYC = (PROG_TIME_NS * (CLK_HZ / 1_000_000)
                            + 999) / 1000;

  typedef enum logic [2:0] {
    ST_BOOT_A, ST_BOOT_B, ST_BOOT_DONE, ST_IDLE, ST_WAIT, ST_ERASE,
    ST_READ
  } dpf_state_e;

  typedef struct packed {
    logic we;
    logic [FA_W-1:0] addr;
    logic [31:0] wdata;
  } dpf_mem_req_s;

  typedef struct packed {
    logic sel;
    logic write;
    logic [7:0] addr;
  } dpf_ahb_phase_s;
endpackage : dpf_pkg

// *** verilog/dpf_flash_array.sv ***
module dpf_flash_array
  import dpf_pkg::*;
(
  // clock
  input wire logic hclk,
  // access
  input wire dpf_mem_req_s req,
  output logic [31:0] rdata
);
  logic [31:0] mem [WORDS];
  logic [31:0] rdata_reg;

  // non-volatile array: no reset, written data persists; a plain clocked
  // process so that words may also be preloaded from outside
  always @(posedge hclk) begin
    if (req.we) begin
      mem[req.addr] <= req.wdata;
    end
  end

  always_ff @(posedge hclk) begin
    rdata_reg <= mem[req.addr];
  end
  assign rdata = rdata_reg;
endmodule : dpf_flash_array

// *** verilog/dpf_boot_check.sv ***
module dpf_boot_check
  import dpf_pkg::*;
(
  // boot sequence words of both partitions
  input wire logic [BOOT_SEQUENCE_NUMBER_WORD_W-1:0] word_p1,
  input wire logic [BOOT_SEQUENCE_NUMBER_WORD_W-1:0] word_p2,
  // selection
  output logic pick_p2
);
  logic valid_p1;
  logic valid_p2;

  // number in low half, complement in high half
  assign valid_p1 = (word_p1[BOOT_SEQUENCE_NUMBER_W-1:0] ==
                     ~word_p1[BOOT_SEQUENCE_NUMBER_WORD_W-1:BOOT_SEQUENCE_NUMBER_W]);
  assign valid_p2 = (word_p2[BOOT_SEQUENCE_NUMBER_W-1:0] ==
                     ~word_p2[BOOT_SEQUENCE_NUMBER_WORD_W-1:BOOT_SEQUENCE_NUMBER_W]);

  always_comb begin
    if (valid_p1 && valid_p2) begin
      pick_p2 = word_p2[BOOT_SEQUENCE_NUMBER_W-1:0] < word_p1[BOOT_SEQUENCE_NUMBER_W-1:0];
    end else begin
      pick_p2 = valid_p2 && !valid_p1;
    end
  end
endmodule : dpf_boot_check

// *** verilog/dpf_flash_ctrl.sv ***
// Functional notes
// - inactive partition erased/programmed while active side keeps running
// - erase select code erases whole inactive partition in one operation
// - boot word is 24 bits: number low, complement high
// - at reset the partition with lower sequence number becomes active
// - one invalid number picks the valid one; both invalid pick partition 1
// - swap exchanges partitions without reset; jump must follow it
// - swap leaves peripherals, interrupts, RAM and stack untouched
// - configuration settings are not reapplied by a swap
// - swap without unlock key acts as no-operation
// - swap-done flag and partition-two-active flag show swap outcome
// - protected mode blocks every erase and write of partition 1
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
module dpf_flash_ctrl
  import dpf_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // interrupt
  output logic irq,
  // partition selection for the fetch path
  output logic p2_active
);
  typedef struct packed {
    dpf_state_e st;
    dpf_ahb_phase_s ph;
    logic [31:0] hrdata;
    logic [3:0] op;
    logic busy;
    logic err;
    logic dual;
    logic protect;
    logic p2_act;
    logic swap_done;
    logic key_half;
    logic unlocked;
    logic [FA_W-1:0] addr;
    logic [31:0] data;
    logic [31:0] rdword;
    logic [BOOT_SEQUENCE_NUMBER_WORD_W-1:0] word_p1;
    logic [7:0] cnt;
    logic [FA_W-1:0] ptr;
    logic [FA_W-1:0] end_ptr;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
  } dpf_state_s;

  dpf_state_s r_reg;
  dpf_state_s r_next;
  dpf_mem_req_s mreq;
  logic [31:0] mrdata;
  logic pick_p2;
  logic wr_hit;
  logic [FA_W-1:0] boot_addr;
  logic [FA_W-1:0] inact_addr;
  logic [FA_W-1:0] page_end;
  logic [IRQ_W-1:0] ev;

  dpf_flash_array i_dpf_flash_array (
    .hclk(hclk),
    .req(mreq),
    .rdata(mrdata)
  );

  dpf_boot_check i_dpf_boot_check (
    .word_p1(r_reg.word_p1),
    .word_p2(mrdata[BOOT_SEQUENCE_NUMBER_WORD_W-1:0]),
    .pick_p2(pick_p2)
  );

  assign wr_hit = r_reg.ph.sel && r_reg.ph.write;
  // the boot word lives in the last word of each partition
  assign boot_addr = {r_reg.st == ST_BOOT_B, {PART_BIT{1'b1}}};
  // software addresses the inactive side; map to its physical half
  assign inact_addr = {!r_reg.p2_act, r_reg.addr[PART_BIT-1:0]};
  assign page_end = {inact_addr[FA_W-1:PAGE_LSB], {PAGE_LSB{1'b1}}};

  always_comb begin
    r_next = r_reg;
    ev = '0;
    mreq.we = 1'b0;
    mreq.addr = r_reg.ptr;
    mreq.wdata = ERASED;
    // address phase capture
    r_next.ph.sel = hsel && hready && htrans[1];
    r_next.ph.write = hwrite;
    r_next.ph.addr = haddr[7:0];
    // read data for the next data phase
    r_next.hrdata = '0;
    if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        OFS_CONTROL: begin
          r_next.hrdata[CTL_BUSY_BIT] = r_reg.busy;
          r_next.hrdata[CTL_ERR_BIT] = r_reg.err;
          r_next.hrdata[CTL_SWAP_DONE_BIT] = r_reg.swap_done;
          r_next.hrdata[CTL_P2_ACTIVE_BIT] = r_reg.p2_act;
          r_next.hrdata[CTL_PROTECT_BIT] = r_reg.protect;
          r_next.hrdata[CTL_DUAL_BIT] = r_reg.dual;
          r_next.hrdata[CTL_OP_LSB +: CTL_OP_W] = r_reg.op;
        end
        OFS_ADDR: r_next.hrdata[FA_W-1:0] = r_reg.addr;
        OFS_DATA: r_next.hrdata = r_reg.data;
        OFS_BOOT: r_next.hrdata[BOOT_SEQUENCE_NUMBER_WORD_W-1:0] = r_reg.word_p1;
        OFS_IRQ_STATUS: r_next.hrdata[IRQ_W-1:0] = r_reg.irq_stat;
        OFS_IRQ_MASK: r_next.hrdata[IRQ_W-1:0] = r_reg.irq_mask;
        OFS_RDDATA: r_next.hrdata = r_reg.rdword;
        default: r_next.hrdata = '0;
      endcase
    end
    // register writes in the data phase
    if (wr_hit) begin
      unique case (r_reg.ph.addr)
        OFS_CONTROL: begin
          r_next.op = hwdata[CTL_OP_LSB +: CTL_OP_W];
          // mode bits are configuration: set once, never by a swap
          r_next.dual = r_reg.dual | hwdata[CTL_DUAL_BIT];
          r_next.protect = r_reg.protect | hwdata[CTL_PROTECT_BIT];
          // writing one clears swap-done unless a swap sets it now
          if (hwdata[CTL_SWAP_DONE_BIT]) begin
            r_next.swap_done = 1'b0;
          end
          if (hwdata[CTL_START_BIT] && !r_reg.busy &&
              r_reg.st == ST_IDLE) begin
            r_next.busy = 1'b1;
            r_next.err = 1'b0;
          end
        end
        OFS_KEY: begin
          // two-write unlock: any other value restarts the sequence
          r_next.key_half = hwdata[7:0] == KEY_FIRST;
          r_next.unlocked = r_reg.key_half &&
                            hwdata[7:0] == KEY_SECOND;
        end
        OFS_ADDR: r_next.addr = hwdata[FA_W-1:0];
        OFS_DATA: r_next.data = hwdata;
        OFS_SWAP: begin
          // soft swap instruction strobe from the core
          if (r_reg.unlocked && r_reg.dual && !r_reg.busy) begin
            r_next.p2_act = !r_reg.p2_act;
            ev[IRQ_SWAP] = 1'b1;
          end
          // without the key the swap is a no-op
          r_next.unlocked = 1'b0;
          r_next.key_half = 1'b0;
        end
        OFS_IRQ_STATUS: r_next.irq_stat = r_reg.irq_stat & ~hwdata[IRQ_W-1:0];
        OFS_IRQ_MASK: r_next.irq_mask = hwdata[IRQ_W-1:0];
        default: r_next.irq_mask = r_reg.irq_mask;
      endcase
    end
    // flash sequencer
    case (r_reg.st)
      ST_BOOT_A: begin
        mreq.addr = boot_addr;
        r_next.st = ST_BOOT_B;
      end
      ST_BOOT_B: begin
        mreq.addr = boot_addr;
        r_next.word_p1 = mrdata[BOOT_SEQUENCE_NUMBER_WORD_W-1:0];
        r_next.st = ST_BOOT_DONE;
      end
      ST_BOOT_DONE: begin
        r_next.p2_act = pick_p2;
        r_next.st = ST_IDLE;
      end
      ST_IDLE: begin
        if (r_reg.busy) begin
          // partition 1 is frozen in protected mode
          if (r_reg.protect && !inact_addr[PART_BIT]
              && r_reg.op != OP_READ) begin
            r_next.err = 1'b1;
            r_next.busy = 1'b0;
            ev[IRQ_ERR] = 1'b1;
          end else begin
            unique case (r_reg.op)
              OP_WORD_PROG: begin
                mreq.we = 1'b1;
                mreq.addr = inact_addr;
                mreq.wdata = r_reg.data;
                r_next.cnt = 8'(PROG_CYC);
                r_next.st = ST_WAIT;
              end
              OP_PAGE_ERASE: begin
                r_next.ptr = {inact_addr[FA_W-1:PAGE_LSB], {PAGE_LSB{1'b0}}};
                r_next.end_ptr = page_end;
                r_next.st = ST_ERASE;
              end
              OP_PART_ERASE: begin
                r_next.ptr = {inact_addr[PART_BIT], {PART_BIT{1'b0}}};
                r_next.end_ptr = {inact_addr[PART_BIT], {PART_BIT{1'b1}}};
                r_next.st = ST_ERASE;
              end
              OP_READ: begin
                mreq.addr = inact_addr;
                r_next.st = ST_READ;
              end
              default: begin
                r_next.err = 1'b1;
                r_next.busy = 1'b0;
                ev[IRQ_ERR] = 1'b1;
              end
            endcase
          end
        end
      end
      ST_WAIT: begin
        r_next.cnt = r_reg.cnt - 8'h01;
        if (r_reg.cnt == 8'h01) begin
          r_next.busy = 1'b0;
          ev[IRQ_OP_DONE] = 1'b1;
          r_next.st = ST_IDLE;
        end
      end
      ST_ERASE: begin
        // one word per cycle, bus stays live the whole time
        mreq.we = 1'b1;
        mreq.addr = r_reg.ptr;
        r_next.ptr = r_reg.ptr + 8'h01;
        if (r_reg.ptr == r_reg.end_ptr) begin
          r_next.busy = 1'b0;
          ev[IRQ_OP_DONE] = 1'b1;
          r_next.st = ST_IDLE;
        end
      end
      ST_READ: begin
        mreq.addr = inact_addr;
        r_next.rdword = mrdata;
        r_next.busy = 1'b0;
        ev[IRQ_OP_DONE] = 1'b1;
        r_next.st = ST_IDLE;
      end
      default: r_next.st = ST_IDLE;
    endcase
    // a completed swap sets the flag even against a clear
    if (ev[IRQ_SWAP]) begin
      r_next.swap_done = 1'b1;
    end
    // events win over a same-cycle clear
    r_next.irq_stat = r_next.irq_stat | ev;
    r_next.irq = |(r_next.irq_stat & r_next.irq_mask);
  end

  // only flash-control state lives here; nothing else is touched by a swap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '{st: ST_BOOT_A, ph: '0, hrdata: '0, op: '0, busy: 1'b0,
                 err: 1'b0, dual: 1'b0, protect: 1'b0, p2_act: 1'b0,
                 swap_done: 1'b0, key_half: 1'b0, unlocked: 1'b0,
                 addr: '0, data: '0, rdword: '0, word_p1: BOOT_SEQUENCE_NUMBER_WORD_RST,
                 cnt: '0, ptr: '0, end_ptr: '0, irq_stat: '0,
                 irq_mask: '0, irq: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign hrdata = r_reg.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = r_reg.irq;
  assign p2_active = r_reg.p2_act;
endmodule : dpf_flash_ctrl

// *** sim/dpf_flash_ctrl_sva.sv ***
module dpf_flash_ctrl_sva
  import dpf_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // status
  input wire logic irq,
  input wire logic p2_active
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] up_reg;
  logic ap_rd;
  logic ap_wr;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) up_reg <= 3'h0;
    else if (up_reg != 3'h4) up_reg <= up_reg + 3'h1;
  end
  assign ap_rd = hsel && hready && htrans[1] && !hwrite;
  assign ap_wr = hsel && hready && htrans[1] && hwrite;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_bus_ready: assert property (hreadyout && !hresp)
    else $error("bus stalled or error response");
  chk_swap_cause: assert property (up_reg == 3'h4
    && $changed(p2_active) |-> $past(ap_wr && haddr[7:0] == OFS_SWAP, 2))
    else $error("partition changed without swap write");
  chk_boot_settle: assert property (up_reg < 3'h3 |-> !p2_active)
    else $error("partition chosen before boot scan ended");
  chk_boot_width: assert property (
    $past(ap_rd && haddr[7:0] == OFS_BOOT) |-> hrdata[31:24] == 8'h00)
    else $error("boot word wider than 24 bits");
  chk_ctl_p2: assert property (
    $past(ap_rd && haddr[7:0] == OFS_CONTROL) && up_reg == 3'h4
    && $stable(p2_active) && p2_active == $past(p2_active, 2)
    |-> hrdata[CTL_P2_ACTIVE_BIT] == p2_active)
    else $error("control flag differs from partition output");
  chk_unmapped_zero: assert property ($past(ap_rd && haddr[7:0] > OFS_RDDATA)
    |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_write_zero: assert property ($past(ap_wr) |-> hrdata == 32'h0)
    else $error("read data during write");
  chk_irq_quiet: assert property ($rose(hresetn) |-> !irq ##1 !irq)
    else $error("interrupt right after reset");
endmodule : dpf_flash_ctrl_sva

bind dpf_flash_ctrl dpf_flash_ctrl_sva i_sva (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .irq(irq), .p2_active(p2_active));

// *** sim/dual_partition_flash_swap_test.sv ***
module dual_partition_flash_swap_test;
  timeunit 1ns;
  timeprecision 1ns;
  import dpf_pkg::*;
  typedef struct {logic [23:0] w1; logic [23:0] w2; logic p2;} dpf_row_s;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, p2_active;
  logic [31:0] haddr, hwdata, hrdata, rd, ctl;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int n_errors, total_checks;
  dpf_row_s rows[6] = '{'{24'hffe001, 24'hffd002, 1'b0},
    '{24'hffa005, 24'hffc003, 1'b1}, '{24'h000005, 24'hffc003, 1'b1},
    '{24'hffa005, 24'h123456, 1'b0}, '{24'hffa005, 24'hffa005, 1'b0},
    '{24'hffffff, 24'h000000, 1'b0}};
  dpf_flash_ctrl i_dpf_flash_ctrl (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .p2_active(p2_active));
  assign hready = hreadyout;
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    rd = hrdata;
    if (n >= 40) begin
      n_errors++;
      final_report();
    end
  endtask : xfer
  task run_op(input logic [3:0] op, input logic [7:0] a);
    int k;
    xfer(OFS_ADDR, 1'b1, {24'h0, a});
    xfer(OFS_CONTROL, 1'b1, ctl | 32'h8000 | {28'h0, op});
    k = 0;
    do begin
      xfer(OFS_CONTROL, 1'b0, 32'h0);
      k++;
    end while (rd[CTL_BUSY_BIT] !== 1'b0 && k < 300);
    if (k >= 300) begin
      n_errors++;
      final_report();
    end
  endtask : run_op
  task rd_word(input logic [7:0] a);
    run_op(OP_READ, a);
    xfer(OFS_RDDATA, 1'b0, 32'h0);
  endtask : rd_word
  task do_reset(input logic [23:0] w1, input logic [23:0] w2);
    i_dpf_flash_ctrl.i_dpf_flash_array.mem[127] = {8'h0, w1};
    i_dpf_flash_ctrl.i_dpf_flash_array.mem[255] = {8'h0, w2};
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    check(irq, 1'b0);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask : do_reset
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    n_errors = 0;
    total_checks = 0;
    foreach (rows[i]) begin
      do_reset(rows[i].w1, rows[i].w2);
      check(p2_active, rows[i].p2);
      xfer(OFS_BOOT, 1'b0, 32'h0);
      check(rd, {8'h0, rows[i].w1});
      xfer(OFS_CONTROL, 1'b0, 32'h0);
      check(rd[CTL_P2_ACTIVE_BIT], rows[i].p2);
      $display("boot row %0d done", i);
    end
    ctl = 32'h0100;
    xfer(OFS_CONTROL, 1'b1, ctl);
    xfer(OFS_SWAP, 1'b1, 32'h0);
    xfer(OFS_KEY, 1'b1, 32'haa);
    xfer(OFS_KEY, 1'b1, 32'h55);
    xfer(OFS_SWAP, 1'b1, 32'h0);
    xfer(OFS_CONTROL, 1'b0, 32'h0);
    check(rd[11:10], 2'b00);
    check(p2_active, 1'b0);
    xfer(OFS_KEY, 1'b1, 32'h55);
    xfer(OFS_KEY, 1'b1, 32'haa);
    xfer(OFS_SWAP, 1'b1, 32'h0);
    xfer(OFS_CONTROL, 1'b0, 32'h0);
    check(rd[11:10], 2'b11);
    check(rd[CTL_DUAL_BIT], 1'b1);
    check(p2_active, 1'b1);
    xfer(OFS_IRQ_STATUS, 1'b0, 32'h0);
    check(rd[IRQ_SWAP], 1'b1);
    check(irq, 1'b0);
    xfer(OFS_IRQ_MASK, 1'b1, 32'h2);
    repeat (2) @(posedge hclk);
    check(irq, 1'b1);
    xfer(OFS_IRQ_STATUS, 1'b1, 32'h2);
    repeat (2) @(posedge hclk);
    check(irq, 1'b0);
    xfer(OFS_CONTROL, 1'b1, 32'h0900);
    xfer(OFS_CONTROL, 1'b0, 32'h0);
    check(rd[CTL_SWAP_DONE_BIT], 1'b0);
    $display("swap tests done");
    xfer(OFS_DATA, 1'b1, 32'h1234_5678);
    run_op(OP_WORD_PROG, 8'h10);
    rd_word(8'h10);
    check(rd, 32'h1234_5678);
    run_op(OP_PART_ERASE, 8'h00);
    check(p2_active, 1'b1);
    rd_word(8'h10);
    check(rd, ERASED);
    rd_word(8'h7f);
    check(rd, ERASED);
    run_op(OP_WORD_PROG, 8'h20);
    run_op(OP_WORD_PROG, 8'h10);
    run_op(OP_PAGE_ERASE, 8'h15);
    rd_word(8'h10);
    check(rd, ERASED);
    rd_word(8'h20);
    check(rd, 32'h1234_5678);
    xfer(OFS_IRQ_STATUS, 1'b0, 32'h0);
    check(rd[IRQ_OP_DONE], 1'b1);
    $display("erase tests done");
    ctl = 32'h0300;
    xfer(OFS_CONTROL, 1'b1, ctl);
    run_op(OP_WORD_PROG, 8'h10);
    xfer(OFS_CONTROL, 1'b0, 32'h0);
    check(rd[CTL_ERR_BIT], 1'b1);
    rd_word(8'h10);
    check(rd, ERASED);
    xfer(OFS_IRQ_STATUS, 1'b0, 32'h0);
    check(rd[IRQ_ERR], 1'b1);
    xfer(8'h24, 1'b1, 32'hffff);
    xfer(8'h24, 1'b0, 32'h0);
    check(rd, 32'h0);
    $display("protect and map tests done");
    final_report();
  end
endmodule : dual_partition_flash_swap_test
